// >>> tb/mgmt_master.sv
// Behavioural station manager that clocks frames over the data line.
`timescale 1ns/1ns

module mgmt_master #(
    parameter HALF = 160
) (
    output reg  mdc,
    output reg  mst_o,
    output reg  mst_oe,
    input  wire mdio_line
);
    // Idle: clock parked low and the line left to the pull-up.
    initial begin
        mdc    = 1'b0;
        mst_o  = 1'b1;
        mst_oe = 1'b0;
    end

    // One frame MSB first; a read hands the line over from the turnaround on.
    // Bits change on the falling edge so they are stable around each rise.
    task xfer(input [31:0] f, input rd, input integer stall, output [15:0] rdat, output ta2);
        integer i;
        begin
            rdat = 16'h0000;
            ta2  = 1'b1;
            for (i = 31; i >= 0; i = i - 1) begin
                mst_oe = !(rd && i < 18);
                mst_o  = f[i];
                #(HALF);
                mdc = 1'b1;
                if (i == 16)
                    ta2 = mdio_line;
                if (i < 16)
                    rdat[i] = mdio_line;
                #(HALF);
                mdc = 1'b0;
                if (i == stall)
                    #(HALF * 20);
            end
            mst_oe = 1'b0;
            // One idle half period, so a following frame never flips the enable in the same step.
            #(HALF);
        end
    endtask
endmodule // mgmt_master

// >>> tb/mgmt_port_asserts.sv
// Concurrent checks on the pins of the station management port.
`timescale 1ns/1ns

module mgmt_port_asserts (
    input wire       mclk,
    input wire       rst_n,
    input wire       mdc,
    input wire       mdio_i,
    input wire       mdio_o,
    input wire       mdio_oe,
    input wire [1:0] config_strap_pins,
    input wire       irq_active_high,
    input wire [7:0] core_event,
    input wire [7:0] inline_power_found,
    input wire [7:0] mgmt_event_irq_n_o,
    input wire [7:0] mgmt_event_irq_n_oe
);
    reg  [7:0] mdc_hist_q;
    reg  [7:0] oe_len_q;
    wire [7:0] any_cause;

    // Either kind of event, kept as one signal so its history can be taken.
    assign any_cause = core_event | inline_power_found;

    // ==========================================================
    // Helper history
    // ==========================================================
    // Recent mdc samples, and how long the data line has been driven.
    always @(posedge mclk) begin
        if (!rst_n) begin
            mdc_hist_q <= 8'h00;
            oe_len_q   <= 8'h00;
        end else begin
            mdc_hist_q <= {mdc_hist_q[6:0], mdc};
            oe_len_q   <= mdio_oe ? oe_len_q + 8'h01 : 8'h00;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Properties
    // ==========================================================
    // The low turnaround bit is followed by a held drive window.
    sequence s_ta_drive;
        !mdio_o ##1 mdio_oe [*5];
    endsequence
    property p_upd_on_rise;
        ($changed(mdio_oe) || (mdio_oe && $changed(mdio_o))) |-> mdc_hist_q[1] && !mdc_hist_q[5];
    endproperty
    property p_stopped;
        mdc_hist_q == 8'h00 |-> $stable(mdio_oe) && $stable(mdio_o);
    endproperty
    property p_ta;
        $rose(mdio_oe) |-> s_ta_drive;
    endproperty
    property p_bit_stand;
        (mdio_oe && $changed(mdio_o)) |=> $stable(mdio_o) [*5];
    endproperty
    property p_oe_len;
        $fell(mdio_oe) |-> oe_len_q >= 8'd102 && oe_len_q <= 8'd140;
    endproperty
    property p_release;
        $fell(mdio_oe) |-> mdio_o;
    endproperty
    property p_irq_level;
        mgmt_event_irq_n_oe != 8'h00 |-> mgmt_event_irq_n_o == {8{irq_active_high}};
    endproperty
    property p_irq_rise;
        (mgmt_event_irq_n_oe & ~$past(mgmt_event_irq_n_oe) & ~$past(any_cause, 2)) != 8'h00
            |-> mdc_hist_q != 8'h00;
    endproperty
    property p_irq_fall;
        ($past(mgmt_event_irq_n_oe) & ~mgmt_event_irq_n_oe) != 8'h00 |-> mdc_hist_q != 8'h00;
    endproperty

    a_upd_on_rise: assert property (p_upd_on_rise)
        else $error("data line changed away from an mdc rise");
    a_stopped: assert property (p_stopped)
        else $error("data line changed while mdc was stopped");
    a_ta: assert property (p_ta)
        else $error("turnaround not driven low");
    a_bit_stand: assert property (p_bit_stand)
        else $error("read bit did not stand until the next rise");
    a_oe_len: assert property (p_oe_len)
        else $error("read drive window has the wrong length");
    a_release: assert property (p_release)
        else $error("line released with a low value");
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt drives the wrong level");
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt rose without a cause");
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without a register access");
endmodule // mgmt_port_asserts

bind station_mgmt_port mgmt_port_asserts u_chk (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .mdc                 (mdc),
    .mdio_i              (mdio_i),
    .mdio_o              (mdio_o),
    .mdio_oe             (mdio_oe),
    .config_strap_pins   (config_strap_pins),
    .irq_active_high     (irq_active_high),
    .core_event          (core_event),
    .inline_power_found  (inline_power_found),
    .mgmt_event_irq_n_o  (mgmt_event_irq_n_o),
    .mgmt_event_irq_n_oe (mgmt_event_irq_n_oe)
);

// >>> tb/tb_top.sv
// Self-checking bench for the station management port.
`timescale 1ns/1ns
`include "mgmt_consts.vh"

module tb_top;
    reg        mclk;
    reg        rst_n;
    reg  [1:0] config_strap_pins;
    reg        irq_active_high;
    reg  [7:0] core_event;
    reg  [7:0] inline_power_found;
    reg        oe_seen;
    reg [15:0] rd_q;
    reg        ta_q;
    wire       mdc;
    wire       mst_o;
    wire       mst_oe;
    wire       mdio_o;
    wire       mdio_oe;
    wire       mdio_line;
    wire [7:0] irq_o;
    wire [7:0] irq_oe;
    wire [7:0] irq_line;
    integer    err_total;
    integer    checks_done;

    // Pull-up on the data line; interrupt lines pulled to the idle level.
    assign mdio_line = mdio_oe ? mdio_o : (mst_oe ? mst_o : 1'b1);
    assign irq_line  = (irq_oe & irq_o) | (~irq_oe & {8{~irq_active_high}});

    station_mgmt_port dut (
        .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
        .config_strap_pins(config_strap_pins), .irq_active_high(irq_active_high), .core_event(core_event),
        .inline_power_found(inline_power_found), .mgmt_event_irq_n_o(irq_o), .mgmt_event_irq_n_oe(irq_oe));
    mgmt_master u_mst (.mdc(mdc), .mst_o(mst_o), .mst_oe(mst_oe), .mdio_line(mdio_line));

    // ==========================================================
    // Clock, drive monitor and helpers
    // ==========================================================
    // Free-running 25 MHz clock.
    always #20 mclk = ~mclk;
    // Remembers any drive of the data line by the port since the last clear.
    always @(posedge mclk) if (mdio_oe) oe_seen <= 1'b1;

    task cmp16(input [8*16-1:0] what, input [15:0] exp, input [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // Pin levels go through the word compare, zero-extended.
    task cmp1(input [8*16-1:0] what, input exp, input got);
        cmp16(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_total);
            if (err_total == 0 && checks_done > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task settle;
        begin
            repeat (8) @(posedge mclk);
            #1;
        end
    endtask
    task wr(input [2:0] p, input [4:0] r, input [15:0] d);
        u_mst.xfer({2'b01, `OP_WRITE, config_strap_pins, p, r, 2'b10, d}, 1'b0, -1, rd_q, ta_q);
    endtask
    // Full five-bit port address, so a wrong address can be sent too.
    task rd(input [4:0] a, input [4:0] r);
        u_mst.xfer({2'b01, `OP_READ, a, r, 2'b11, 16'hffff}, 1'b1, -1, rd_q, ta_q);
    endtask
    task pulse(input [7:0] ev, input [7:0] ip);
        begin
            settle;
            @(posedge mclk);
            core_event         <= ev;
            inline_power_found <= ip;
            @(posedge mclk);
            core_event         <= 8'h00;
            inline_power_found <= 8'h00;
            settle;
        end
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Write with the clock stopped mid-frame, then reads with and without preamble.
    task t_rw;
        begin
            u_mst.xfer({2'b01, `OP_WRITE, config_strap_pins, 3'd3, 5'd5, 2'b10, 16'ha5c3}, 1'b0, 20, rd_q, ta_q);
            rd({config_strap_pins, 3'd3}, 5'd5);
            cmp1("turnaround", 1'b0, ta_q);
            cmp16("read back", 16'ha5c3, rd_q);
            u_mst.xfer(32'hffffffff, 1'b0, -1, rd_q, ta_q);
            rd({config_strap_pins, 3'd3}, 5'd5);
            cmp16("after preamble", 16'ha5c3, rd_q);
            $display("t_rw done");
        end
    endtask
    // Bad start, opcodes 00 and 11: nothing driven, next frame still works.
    task t_bad;
        begin
            oe_seen = 1'b0;
            u_mst.xfer(32'h3fffffff, 1'b0, -1, rd_q, ta_q);
            u_mst.xfer(32'h4fffffff, 1'b0, -1, rd_q, ta_q);
            u_mst.xfer(32'h7fffffff, 1'b0, -1, rd_q, ta_q);
            cmp1("bad frame drive", 1'b0, oe_seen);
            rd({config_strap_pins, 3'd3}, 5'd5);
            cmp16("after bad", 16'ha5c3, rd_q);
            $display("t_bad done");
        end
    endtask
    // Every port, a foreign address, and a change of the strap pins.
    task t_ports;
        integer p;
        begin
            for (p = 0; p < 8; p = p + 1)
                wr(p[2:0], 5'd7, 16'h7000 | p[15:0]);
            for (p = 0; p < 8; p = p + 1) begin
                rd({config_strap_pins, p[2:0]}, 5'd7);
                cmp16("port word", 16'h7000 | p[15:0], rd_q);
            end
            oe_seen = 1'b0;
            rd({~config_strap_pins, 3'd1}, 5'd7);
            cmp1("foreign drive", 1'b0, oe_seen);
            @(posedge mclk);
            config_strap_pins <= 2'b01;
            settle;
            rd(5'b01011, 5'd7);
            cmp16("new strap", 16'h7003, rd_q);
            $display("t_ports done");
        end
    endtask
    // Extended page overlays registers 16..30 only.
    task t_page;
        begin
            wr(3'd2, 5'd31, 16'h0001);
            wr(3'd2, 5'd20, 16'h1111);
            wr(3'd2, 5'd31, 16'h0000);
            wr(3'd2, 5'd20, 16'h2222);
            rd({config_strap_pins, 3'd2}, 5'd20);
            cmp16("main page", 16'h2222, rd_q);
            wr(3'd2, 5'd31, 16'h0001);
            rd({config_strap_pins, 3'd2}, 5'd20);
            cmp16("ext page", 16'h1111, rd_q);
            rd({config_strap_pins, 3'd2}, 5'd7);
            cmp16("low reg on ext", 16'h7002, rd_q);
            wr(3'd2, 5'd31, 16'h0000);
            $display("t_page done");
        end
    endtask
    // Events on port 4: enabled, cleared by reading, masked, then unmasked.
    task t_irq(input pol);
        begin
            @(posedge mclk);
            irq_active_high <= pol;
            wr(3'd4, 5'd25, 16'h8000);
            pulse(8'h10, 8'h00);
            cmp16("irq enables", 16'h0010, {8'h00, irq_oe});
            cmp1("irq wire on", pol, irq_line[4]);
            rd({config_strap_pins, 3'd4}, 5'd26);
            settle;
            cmp16("event status", 16'h8000, rd_q & 16'h8200);
            cmp1("irq wire off", !pol, irq_line[4]);
            pulse(8'h00, 8'h10);
            cmp1("power irq", 1'b1, irq_oe[4]);
            rd({config_strap_pins, 3'd4}, 5'd26);
            settle;
            cmp16("power status", 16'h0200, rd_q & 16'h8200);
            cmp1("power cleared", 1'b0, irq_oe[4]);
            rd({config_strap_pins, 3'd4}, 5'd26);
            cmp16("status reread", 16'h0000, rd_q & 16'h8200);
            wr(3'd4, 5'd25, 16'h0000);
            pulse(8'h10, 8'h00);
            cmp16("masked", 16'h0000, {8'h00, irq_oe});
            wr(3'd4, 5'd25, 16'h8000);
            settle;
            cmp1("latched event", 1'b1, irq_oe[4]);
            rd({config_strap_pins, 3'd4}, 5'd26);
            settle;
            cmp1("latched cleared", 1'b0, irq_oe[4]);
            $display("t_irq done");
        end
    endtask

    // Reset for 20 cycles, then the scenarios and the verdict.
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        config_strap_pins = 2'b11;
        irq_active_high = 1'b0;
        core_event = 8'h00;
        inline_power_found = 8'h00;
        oe_seen = 1'b0;
        err_total = 0;
        checks_done = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        #7;
        t_rw;
        t_bad;
        t_ports;
        t_page;
        t_irq(1'b0);
        t_irq(1'b1);
        summarize;
    end
    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge mclk);
        err_total = err_total + 1;
        $display("[FAIL] watchdog expired");
        summarize;
    end
endmodule // tb_top

// >>> verilog/mgmt_consts.vh
// Constants shared by the station management port and its register bank.
`ifndef MGMT_CONSTS_VH
`define MGMT_CONSTS_VH

// =============================================================
// Frame layout
// =============================================================
`define OP_READ          2'b10
`define OP_WRITE         2'b01
`define ADDR_BITS        5'd10
`define DATA_BITS        5'd16
`define SKIP_BITS        5'd18
`define PORT_ADDR_HI     9
`define PORT_ADDR_LO     5

// =============================================================
// Register numbers and field positions
// =============================================================
`define NUM_PORTS        8
`define REG_IRQ_CTL      5'd25
`define REG_IRQ_STAT     5'd26
`define REG_PAGE         5'd31
`define IRQ_EN_BIT       15
`define EVT_STAT_BIT     15
`define IPD_STAT_BIT     9
`define BANK_AW          9

// =============================================================
// Reset values and timing
// =============================================================
`define IRQ_EN_RST       1'b0
`define PAGE_RST         1'b0
`define MCLK_HZ          25000000
`define MDC_MAX_HZ       12500000

`endif

// >>> verilog/reg_bank.v
// Register bank memory: eight ports, main and extended page, 16-bit words.
`timescale 1ns/1ns
`include "mgmt_consts.vh"

module reg_bank (
    clk,
    wr_en,
    wr_addr,
    wr_data,
    rd_en,
    rd_addr,
    rd_data_q
);
    input  wire                      clk;
    input  wire                      wr_en;
    input  wire [`BANK_AW-1:0]       wr_addr;
    input  wire [15:0]               wr_data;
    input  wire                      rd_en;
    input  wire [`BANK_AW-1:0]       rd_addr;
    output reg  [15:0]               rd_data_q;

    reg [15:0] mem [0:(1<<`BANK_AW)-1];

    // =============================================================
    // Storage
    // =============================================================
    // Contents are not reset; software is expected to program what it uses.
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule // reg_bank

// >>> verilog/station_mgmt_port.v
// Serial station management port with per-port interrupt outputs.
`timescale 1ns/1ns
`include "mgmt_consts.vh"

module station_mgmt_port (
    mclk,
    rst_n,
    mdc,
    mdio_i,
    mdio_o,
    mdio_oe,
    config_strap_pins,
    irq_active_high,
    core_event,
    inline_power_found,
    mgmt_event_irq_n_o,
    mgmt_event_irq_n_oe
);
    input  wire                      mclk;
    input  wire                      rst_n;
    input  wire                      mdc;
    input  wire                      mdio_i;
    output reg                       mdio_o;
    output reg                       mdio_oe;
    input  wire [1:0]                config_strap_pins;
    input  wire                      irq_active_high;
    input  wire [`NUM_PORTS-1:0]     core_event;
    input  wire [`NUM_PORTS-1:0]     inline_power_found;
    output reg  [`NUM_PORTS-1:0]     mgmt_event_irq_n_o;
    output reg  [`NUM_PORTS-1:0]     mgmt_event_irq_n_oe;

    // One-hot frame states.
    localparam [7:0] ST_IDLE  = 8'h01;
    localparam [7:0] ST_START = 8'h02;
    localparam [7:0] ST_OP    = 8'h04;
    localparam [7:0] ST_ADDR  = 8'h08;
    localparam [7:0] ST_TA    = 8'h10;
    localparam [7:0] ST_DATA  = 8'h20;
    localparam [7:0] ST_SKIP  = 8'h40;
    localparam [7:0] ST_LOCK  = 8'h80;

    // =============================================================
    // Pin synchronisers
    // =============================================================
    reg        mdc_s1_q;
    reg        mdc_s2_q;
    reg        mdc_s3_q;
    reg        mdio_s1_q;
    reg        mdio_s2_q;
    reg  [1:0] strap_s1_q;
    reg  [1:0] strap_s2_q;
    reg        pol_s1_q;
    reg        pol_s2_q;
    wire       mdc_rise;
    wire       bit_in;

    // The mdio, strap and polarity pins pass two flops and only the second stage feeds logic; mdc gets a third flop, and its edge uses stages two and three.
    always @(posedge mclk) begin
        if (!rst_n) begin
            mdc_s1_q   <= 1'b0;
            mdc_s2_q   <= 1'b0;
            mdc_s3_q   <= 1'b0;
            mdio_s1_q  <= 1'b1;
            mdio_s2_q  <= 1'b1;
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
            pol_s1_q   <= 1'b0;
            pol_s2_q   <= 1'b0;
        end else begin
            mdc_s1_q   <= mdc;
            mdc_s2_q   <= mdc_s1_q;
            mdc_s3_q   <= mdc_s2_q;
            mdio_s1_q  <= mdio_i;
            mdio_s2_q  <= mdio_s1_q;
            strap_s1_q <= config_strap_pins;
            strap_s2_q <= strap_s1_q;
            pol_s1_q   <= irq_active_high;
            pol_s2_q   <= pol_s1_q;
        end
    end

    // Only rising edges move the frame; a stopped clock just holds state.
    assign mdc_rise = mdc_s2_q & ~mdc_s3_q;
    assign bit_in   = mdio_s2_q;

    // =============================================================
    // Frame decoder
    // =============================================================
    reg  [7:0]            state_q;
    reg  [4:0]            cnt_q;
    reg  [1:0]            op_q;
    reg                   is_rd_q;
    reg  [9:0]            addr_q;
    reg  [15:0]           wsh_q;
    reg  [15:0]           rsh_q;
    reg                   rd_en_q;
    reg                   rd_pend_q;
    reg                   wr_en_q;
    reg  [`BANK_AW-1:0]   wr_addr_q;
    reg  [15:0]           wr_data_q;
    reg  [`NUM_PORTS-1:0] page_q;
    reg  [`NUM_PORTS-1:0] irq_en_q;
    reg  [`NUM_PORTS-1:0] evt_stat_q;
    reg  [`NUM_PORTS-1:0] ipd_stat_q;
    wire [1:0]            op_new;
    wire [9:0]            addr_new;
    wire [2:0]            port_sel;
    wire [4:0]            reg_sel;
    wire                  page_hi;
    wire [`BANK_AW-1:0]   bank_addr;
    wire [15:0]           rd_data;
    wire [15:0]           stat_word;

    assign op_new   = {op_q[0], bit_in};
    assign addr_new = {addr_q[8:0], bit_in};
    // Port and register come from the address shifter once it is full.
    assign port_sel = addr_q[7:5];
    assign reg_sel  = addr_q[4:0];
    // Registers 16..30 follow the page select; 0..15 and 31 never move.
    assign page_hi   = page_q[port_sel] & reg_sel[4] & (reg_sel != `REG_PAGE);
    assign bank_addr = {port_sel, page_hi, reg_sel};
    assign stat_word = {evt_stat_q[port_sel], 5'h00, ipd_stat_q[port_sel], 9'h000};

    // Bit-serial decode; every transition waits for a management clock rise.
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            cnt_q     <= 5'h00;
            op_q      <= 2'h0;
            is_rd_q   <= 1'b0;
            addr_q    <= 10'h000;
            wsh_q     <= 16'h0000;
            rsh_q     <= 16'h0000;
            rd_en_q   <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_en_q   <= 1'b0;
            wr_addr_q <= {`BANK_AW{1'b0}};
            wr_data_q <= 16'h0000;
            mdio_o    <= 1'b1;
            mdio_oe   <= 1'b0;
        end else begin
            rd_en_q   <= 1'b0;
            wr_en_q   <= 1'b0;
            rd_pend_q <= rd_en_q;
            // Read data lands one cycle after the bank read; status overrides it.
            if (rd_pend_q) begin
                rsh_q <= (reg_sel == `REG_IRQ_STAT) ? stat_word : rd_data;
            end
            if (mdc_rise) begin
                case (state_q)
                    ST_IDLE: begin
                        // Ones are preamble and are simply skipped.
                        mdio_oe <= 1'b0;
                        if (!bit_in) begin
                            state_q <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (bit_in) begin
                            state_q <= ST_OP;
                            cnt_q   <= 5'h00;
                        end else begin
                            state_q <= ST_LOCK;
                        end
                    end
                    ST_OP: begin
                        op_q  <= op_new;
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'h01) begin
                            cnt_q   <= 5'h00;
                            is_rd_q <= (op_new == `OP_READ);
                            if (op_new == `OP_READ || op_new == `OP_WRITE) begin
                                state_q <= ST_ADDR;
                            end else begin
                                state_q <= ST_LOCK;
                            end
                        end
                    end
                    ST_ADDR: begin
                        addr_q <= addr_new;
                        cnt_q  <= cnt_q + 5'h01;
                        if (cnt_q == `ADDR_BITS - 5'h01) begin
                            cnt_q <= 5'h00;
                            // Only the strap bits can miss: all eight port codes exist.
                            if (addr_new[`PORT_ADDR_HI:`PORT_ADDR_HI-1] == strap_s2_q) begin
                                state_q <= ST_TA;
                                rd_en_q <= is_rd_q;
                            end else begin
                                state_q <= ST_SKIP;
                            end
                        end
                    end
                    ST_TA: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'h00) begin
                            // First turnaround bit is left released; a read drives zero now, a write drives nothing.
                            mdio_o  <= 1'b0;
                            mdio_oe <= is_rd_q;
                        end else begin
                            state_q <= ST_DATA;
                            cnt_q   <= 5'h00;
                            mdio_o  <= rsh_q[15];
                            rsh_q   <= {rsh_q[14:0], 1'b0};
                        end
                    end
                    ST_DATA: begin
                        // Write bits are sampled at this rise, read bits change here.
                        wsh_q  <= {wsh_q[14:0], bit_in};
                        mdio_o <= rsh_q[15];
                        rsh_q  <= {rsh_q[14:0], 1'b0};
                        cnt_q  <= cnt_q + 5'h01;
                        if (cnt_q == `DATA_BITS - 5'h01) begin
                            state_q   <= ST_IDLE;
                            mdio_oe   <= 1'b0;
                            mdio_o    <= 1'b1;
                            wr_en_q   <= ~is_rd_q;
                            wr_addr_q <= bank_addr;
                            wr_data_q <= {wsh_q[14:0], bit_in};
                        end
                    end
                    ST_SKIP: begin
                        // Another device owns this frame; stay silent to its end.
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == `SKIP_BITS - 5'h01) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_LOCK: begin
                        if (bit_in) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        mdio_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // =============================================================
    // Register storage
    // =============================================================
    // The bank read is issued once the register address is known, giving
    // several system clocks before the first data bit must leave.
    reg_bank u_bank (
        .clk       (mclk),
        .wr_en     (wr_en_q),
        .wr_addr   (wr_addr_q),
        .wr_data   (wr_data_q),
        .rd_en     (rd_en_q),
        .rd_addr   (bank_addr),
        .rd_data_q (rd_data)
    );

    // =============================================================
    // Per-port control, status and interrupt pins
    // =============================================================
    // This logic has no tie to the port's power state, so it keeps
    // running while the port's main logic sleeps.
    genvar p;
    generate
        for (p = 0; p < `NUM_PORTS; p = p + 1) begin : g_port
            wire wr_hit;
            wire rd_clr;
            wire pend;

            assign wr_hit = wr_en_q && (wr_addr_q[8:6] == p);
            assign rd_clr = rd_pend_q && (port_sel == p) && (reg_sel == `REG_IRQ_STAT);
            assign pend   = irq_en_q[p] & (evt_stat_q[p] | ipd_stat_q[p]);

            // Shadow of the page select and interrupt enable fields.
            always @(posedge mclk) begin
                if (!rst_n) begin
                    page_q[p]   <= `PAGE_RST;
                    irq_en_q[p] <= `IRQ_EN_RST;
                end else if (wr_hit) begin
                    if (wr_addr_q[4:0] == `REG_PAGE) begin
                        page_q[p] <= |wr_data_q;
                    end
                    if (wr_addr_q[4:0] == `REG_IRQ_CTL && !wr_addr_q[5]) begin
                        irq_en_q[p] <= wr_data_q[`IRQ_EN_BIT];
                    end
                end
            end

            // Sticky status, cleared by reading; a new event in the same
            // cycle as the clearing read survives.
            always @(posedge mclk) begin
                if (!rst_n) begin
                    evt_stat_q[p] <= 1'b0;
                    ipd_stat_q[p] <= 1'b0;
                end else begin
                    evt_stat_q[p] <= core_event[p] | (evt_stat_q[p] & ~rd_clr);
                    ipd_stat_q[p] <= inline_power_found[p] | (ipd_stat_q[p] & ~rd_clr);
                end
            end

            // Drive only the asserted level; the pull resistor sets idle.
            always @(posedge mclk) begin
                if (!rst_n) begin
                    mgmt_event_irq_n_o[p]  <= 1'b0;
                    mgmt_event_irq_n_oe[p] <= 1'b0;
                end else begin
                    mgmt_event_irq_n_o[p]  <= pol_s2_q;
                    mgmt_event_irq_n_oe[p] <= pend;
                end
            end
        end
    endgenerate
endmodule // station_mgmt_port
